// ---- hdl/bsc_boot_cmd.sv ----
`timescale 1ns/100ps
// How it works
// R1: A first byte of fd hex is taken as the request for the check value.
// R2: The check value goes back low byte first, then high byte.
// R3: Taking that request also returns the check value to its seed.
// R4: Every page-program data byte updates the check value until the next request.
// R5: The check value is a cyclic redundancy check over those data bytes.
// R6: Code b0 hex is echoed, then the serial rate becomes 9600 bps.
// R7: Code b1 hex is echoed, then the serial rate becomes 19200 bps.
// R8: Code b2 hex is echoed, and only after that the rate becomes 38400 bps.
// R9: Code b3 hex is echoed, then the serial rate becomes 57600 bps.
// R10: Page program is code 41 hex, two address bytes, then 256 data bytes.
// R11: The check uses polynomial 1021 hex with a fixed seed of ffff hex.
// R12: The new rate applies to receive and transmit only after the echo stop bit ends.
module bsc_boot_cmd #(
	parameter int DIV_9600  = bsc_pkg::DIV_9600,
	parameter int DIV_19200 = bsc_pkg::DIV_19200,
	parameter int DIV_38400 = bsc_pkg::DIV_38400,
	parameter int DIV_57600 = bsc_pkg::DIV_57600
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	input  wire logic              rxd,
	output logic                   txd,
	output bsc_pkg::bsc_rate_t     rate,
	output logic [15:0]            check_value,
	output logic                   cmd_busy
);

	// ****************************************************************
	// Shared helpers
	// ****************************************************************
	function automatic logic [bsc_pkg::DIV_W-1:0] div_of(input bsc_pkg::bsc_rate_t r);
		case (r)
			bsc_pkg::RATE_9600:  div_of = DIV_9600[bsc_pkg::DIV_W-1:0];
			bsc_pkg::RATE_19200: div_of = DIV_19200[bsc_pkg::DIV_W-1:0];
			bsc_pkg::RATE_38400: div_of = DIV_38400[bsc_pkg::DIV_W-1:0];
			bsc_pkg::RATE_57600: div_of = DIV_57600[bsc_pkg::DIV_W-1:0];
			default:             div_of = DIV_9600[bsc_pkg::DIV_W-1:0];
		endcase
	endfunction

	logic [bsc_pkg::DIV_W-1:0] bit_div;
	assign bit_div = div_of(rate);

	// ****************************************************************
	// Receiver
	// ****************************************************************
	logic                      rx_s1;
	logic                      rx_s2;
	logic                      rx_busy;
	logic [bsc_pkg::DIV_W-1:0] rx_cnt;
	logic [3:0]                rx_bit;
	logic [7:0]                rx_sh;
	bsc_pkg::bsc_byte_t        rx_out;
	logic                      next_rx_busy;
	logic [bsc_pkg::DIV_W-1:0] next_rx_cnt;
	logic [3:0]                next_rx_bit;
	logic [7:0]                next_rx_sh;
	bsc_pkg::bsc_byte_t        next_rx_out;

	always_comb
	begin
		next_rx_busy = rx_busy;
		next_rx_cnt  = rx_cnt;
		next_rx_bit  = rx_bit;
		next_rx_sh   = rx_sh;
		next_rx_out  = '{valid: 1'b0, data: rx_out.data};
		if (!rx_busy)
		begin
			if (!rx_s2)
			begin
				// Sampling lands mid-bit, half a period after the start edge.
				next_rx_busy = 1'b1;
				next_rx_cnt  = bit_div >> 1;
				next_rx_bit  = 4'h0;
			end
		end
		else if (rx_cnt != '0)
			next_rx_cnt = rx_cnt - 1'b1;
		else
		begin
			next_rx_cnt = bit_div - 1'b1;
			if (rx_bit == 4'h0)
			begin
				if (rx_s2)
					next_rx_busy = 1'b0;
				else
					next_rx_bit = 4'h1;
			end
			else if (rx_bit < 4'(bsc_pkg::FRAME_LAST))
			begin
				next_rx_sh  = {rx_s2, rx_sh[7:1]};
				next_rx_bit = rx_bit + 1'b1;
			end
			else
			begin
				// A byte with a low stop bit is dropped as a framing error.
				next_rx_busy = 1'b0;
				next_rx_out  = '{valid: rx_s2, data: rx_sh};
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_s1   <= 1'b1;
			rx_s2   <= 1'b1;
			rx_busy <= 1'b0;
			rx_cnt  <= '0;
			rx_bit  <= 4'h0;
			rx_sh   <= 8'h00;
			rx_out  <= '0;
		end
		else if (ce)
		begin
			rx_s1   <= rxd;
			rx_s2   <= rx_s1;
			rx_busy <= next_rx_busy;
			rx_cnt  <= next_rx_cnt;
			rx_bit  <= next_rx_bit;
			rx_sh   <= next_rx_sh;
			rx_out  <= next_rx_out;
		end
	end

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	logic                      tx_go;
	logic [7:0]                tx_byte;
	logic                      tx_busy;
	logic [bsc_pkg::DIV_W-1:0] tx_cnt;
	logic [3:0]                tx_bit;
	logic [9:0]                tx_sh;
	logic                      next_tx_busy;
	logic [bsc_pkg::DIV_W-1:0] next_tx_cnt;
	logic [3:0]                next_tx_bit;
	logic [9:0]                next_tx_sh;
	logic                      next_txd;

	always_comb
	begin
		next_tx_busy = tx_busy;
		next_tx_cnt  = tx_cnt;
		next_tx_bit  = tx_bit;
		next_tx_sh   = tx_sh;
		if (!tx_busy)
		begin
			if (tx_go)
			begin
				next_tx_busy = 1'b1;
				next_tx_sh   = {1'b1, tx_byte, 1'b0};
				next_tx_cnt  = bit_div - 1'b1;
				next_tx_bit  = 4'h0;
			end
		end
		else if (tx_cnt != '0)
			next_tx_cnt = tx_cnt - 1'b1;
		else if (tx_bit == 4'(bsc_pkg::FRAME_LAST))
			next_tx_busy = 1'b0;  // R12
		else
		begin
			next_tx_sh  = {1'b1, tx_sh[9:1]};
			next_tx_bit = tx_bit + 1'b1;
			next_tx_cnt = bit_div - 1'b1;
		end
		next_txd = next_tx_busy ? next_tx_sh[0] : 1'b1;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_busy <= 1'b0;
			tx_cnt  <= '0;
			tx_bit  <= 4'h0;
			tx_sh   <= 10'h3ff;
			txd     <= 1'b1;
		end
		else if (ce)
		begin
			tx_busy <= next_tx_busy;
			tx_cnt  <= next_tx_cnt;
			tx_bit  <= next_tx_bit;
			tx_sh   <= next_tx_sh;
			txd     <= next_txd;
		end
	end

	// ****************************************************************
	// Command interpreter
	// ****************************************************************
	bsc_pkg::bsc_state_t state;
	logic [8:0]          cnt;
	logic [15:0]         snd;
	logic [1:0]          snd_left;
	logic                pend;
	bsc_pkg::bsc_rate_t  pend_rate;
	logic                crc_clear;
	bsc_pkg::bsc_byte_t  crc_in;
	bsc_pkg::bsc_state_t next_state;
	logic [8:0]          next_cnt;
	logic [15:0]         next_snd;
	logic [1:0]          next_snd_left;
	logic                next_pend;
	bsc_pkg::bsc_rate_t  next_pend_rate;
	bsc_pkg::bsc_rate_t  next_rate;
	logic                next_tx_go;

	bsc_crc16 u_crc (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.clear   (crc_clear),
		.din     (crc_in),
		.crc     (check_value)
	);

	always_comb
	begin
		next_state     = state;
		next_cnt       = cnt;
		next_snd       = snd;
		next_snd_left  = snd_left;
		next_pend      = pend;
		next_pend_rate = pend_rate;
		next_rate      = rate;
		next_tx_go     = 1'b0;
		crc_clear      = 1'b0;
		crc_in         = '{valid: 1'b0, data: rx_out.data};
		case (state)
			bsc_pkg::ST_CMD:
				if (rx_out.valid)
				begin
					case (rx_out.data)
						bsc_pkg::CMD_CHECK:  // R1
						begin
							next_snd      = check_value;  // R2
							next_snd_left = 2'h2;
							crc_clear     = 1'b1;  // R3
							next_state    = bsc_pkg::ST_SEND;
						end
						bsc_pkg::CMD_PROG:  // R10
						begin
							next_cnt   = 9'(bsc_pkg::ADDR_BYTES - 1);
							next_state = bsc_pkg::ST_ADDR;
						end
						bsc_pkg::CMD_B9600, bsc_pkg::CMD_B19200,
						bsc_pkg::CMD_B38400, bsc_pkg::CMD_B57600:  // R6 R7 R8 R9
						begin
							next_snd       = {8'h00, rx_out.data};
							next_snd_left  = 2'h1;
							next_pend      = 1'b1;
							next_pend_rate = bsc_pkg::bsc_rate_t'(rx_out.data[1:0]);
							next_state     = bsc_pkg::ST_SEND;
						end
						default:
							next_state = bsc_pkg::ST_CMD;
					endcase
				end
			bsc_pkg::ST_ADDR:
				if (rx_out.valid)
				begin
					next_cnt = cnt - 1'b1;
					if (cnt == '0)
					begin
						next_cnt   = 9'(bsc_pkg::PAGE_BYTES - 1);
						next_state = bsc_pkg::ST_DATA;
					end
				end
			bsc_pkg::ST_DATA:
				if (rx_out.valid)
				begin
					crc_in   = rx_out;  // R4 R10
					next_cnt = cnt - 1'b1;
					if (cnt == '0)
						next_state = bsc_pkg::ST_CMD;
				end
			bsc_pkg::ST_SEND:
				// Waiting for the line to be idle also covers the go pulse in flight.
				if (!tx_busy && !tx_go)
				begin
					if (snd_left == 2'h0)
					begin
						if (pend)
							next_rate = pend_rate;  // R12 R8
						next_pend  = 1'b0;
						next_state = bsc_pkg::ST_CMD;
					end
					else
					begin
						next_tx_go    = 1'b1;
						next_snd      = {8'h00, snd[15:8]};
						next_snd_left = snd_left - 1'b1;
					end
				end
			default:
				next_state = bsc_pkg::ST_CMD;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state     <= bsc_pkg::ST_CMD;
			cnt       <= 9'h000;
			snd       <= 16'h0000;
			snd_left  <= 2'h0;
			pend      <= 1'b0;
			pend_rate <= bsc_pkg::RATE_RESET;
			rate      <= bsc_pkg::RATE_RESET;
			tx_go     <= 1'b0;
			tx_byte   <= 8'h00;
		end
		else if (ce)
		begin
			state     <= next_state;
			cnt       <= next_cnt;
			snd       <= next_snd;
			snd_left  <= next_snd_left;
			pend      <= next_pend;
			pend_rate <= next_pend_rate;
			rate      <= next_rate;
			tx_go     <= next_tx_go;
			tx_byte   <= snd[7:0];
		end
	end

	assign cmd_busy = (state != bsc_pkg::ST_CMD);

endmodule // bsc_boot_cmd

// ---- hdl/bsc_crc16.sv ----
`timescale 1ns/100ps
module bsc_crc16 (
	input  wire logic            mclk,
	input  wire logic            sys_rst,
	input  wire logic            ce,
	input  wire logic            clear,
	input  wire bsc_pkg::bsc_byte_t din,
	output logic [15:0]          crc
);

	// ****************************************************************
	// Byte-wise update, MSB first, no reflection
	// ****************************************************************
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ((r << 1) ^ bsc_pkg::CRC_POLY) : (r << 1);
		return r;
	endfunction

	logic [15:0] next_crc;

	always_comb
	begin
		next_crc = crc;
		if (clear)
			next_crc = bsc_pkg::CRC_SEED;  // R3
		else if (din.valid)
			next_crc = crc_step(crc, din.data);  // R5 R11
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			crc <= bsc_pkg::CRC_SEED;
		else if (ce)
			crc <= next_crc;
	end

endmodule // bsc_crc16

// ---- hdl/bsc_pkg.sv ----
package bsc_pkg;

	// ****************************************************************
	// Clock and serial rates
	// ****************************************************************
	localparam int CLK_HZ     = 200_000_000;
	localparam int BAUD_9600  = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int BAUD_38400 = 38400;
	localparam int BAUD_57600 = 57600;
	localparam int DIV_9600   = (CLK_HZ + BAUD_9600 / 2) / BAUD_9600;
	localparam int DIV_19200  = (CLK_HZ + BAUD_19200 / 2) / BAUD_19200;
	localparam int DIV_38400  = (CLK_HZ + BAUD_38400 / 2) / BAUD_38400;
	localparam int DIV_57600  = (CLK_HZ + BAUD_57600 / 2) / BAUD_57600;
	localparam int DIV_W      = 16;
	localparam int FRAME_LAST = 9;

	// ****************************************************************
	// Command codes and frame layout
	// ****************************************************************
	localparam logic [7:0] CMD_CHECK  = 8'hfd;
	localparam logic [7:0] CMD_PROG   = 8'h41;
	localparam logic [7:0] CMD_B9600  = 8'hb0;
	localparam logic [7:0] CMD_B19200 = 8'hb1;
	localparam logic [7:0] CMD_B38400 = 8'hb2;
	localparam logic [7:0] CMD_B57600 = 8'hb3;
	localparam int         ADDR_BYTES = 2;
	localparam int         PAGE_BYTES = 256;

	// ****************************************************************
	// Check value computation
	// ****************************************************************
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_SEED = 16'hffff;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} bsc_byte_t;

	typedef enum logic [1:0] {
		RATE_9600  = 2'h0,
		RATE_19200 = 2'h1,
		RATE_38400 = 2'h2,
		RATE_57600 = 2'h3
	} bsc_rate_t;

	localparam bsc_rate_t RATE_RESET = RATE_9600;

	typedef enum logic [3:0] {
		ST_CMD  = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h4,
		ST_SEND = 4'h8
	} bsc_state_t;

endpackage

// ---- tb/bsc_boot_cmd_properties.sv ----
`timescale 1ns/100ps
module bsc_boot_cmd_properties #(
	parameter int DIV_9600  = 64,
	parameter int DIV_19200 = 32,
	parameter int DIV_38400 = 16,
	parameter int DIV_57600 = 8
) (
	input wire logic               mclk,
	input wire logic               sys_rst,
	input wire logic               ce,
	input wire logic               rxd,
	input wire logic               txd,
	input wire bsc_pkg::bsc_rate_t rate,
	input wire logic [15:0]        check_value,
	input wire logic               cmd_busy
);
	// ****************************************************************
	// Line run-length counters
	// ****************************************************************
	logic [31:0] lo_cnt;
	logic [31:0] hi_cnt;

	function automatic int div_of(input bsc_pkg::bsc_rate_t r);
		case (r)
			bsc_pkg::RATE_9600:  return DIV_9600;
			bsc_pkg::RATE_19200: return DIV_19200;
			bsc_pkg::RATE_38400: return DIV_38400;
			default:             return DIV_57600;
		endcase
	endfunction

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lo_cnt <= '0;
			hi_cnt <= '0;
		end
		else
		begin
			lo_cnt <= txd ? 32'h0 : lo_cnt + 32'h1;
			hi_cnt <= txd ? hi_cnt + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_rate_at_end; !$stable(rate) |-> $fell(cmd_busy); endproperty
	a_rate_at_end: assert property (p_rate_at_end) else $error("rate moved mid command");
	property p_rate_after_stop; !$stable(rate) |-> hi_cnt >= div_of($past(rate)); endproperty
	a_rate_after_stop: assert property (p_rate_after_stop) else $error("rate moved early");
	property p_idle_line; !cmd_busy |-> txd; endproperty
	a_idle_line: assert property (p_idle_line) else $error("txd low while idle");
	property p_tx_in_cmd; $fell(txd) |-> cmd_busy; endproperty
	a_tx_in_cmd: assert property (p_tx_in_cmd) else $error("start bit outside command");
	// Every low run on txd is a whole number of bit periods.
	property p_bit_len; $rose(txd) |-> (lo_cnt % div_of(rate)) == 0; endproperty
	a_bit_len: assert property (p_bit_len) else $error("bad bit length");
	property p_crc_in_cmd; !$stable(check_value) |-> cmd_busy || $past(cmd_busy); endproperty
	a_crc_in_cmd: assert property (p_crc_in_cmd) else $error("check value moved idle");
	property p_seed_at_req;
		check_value == 16'hffff && $past(check_value) != 16'hffff |-> $rose(cmd_busy);
	endproperty
	a_seed_at_req: assert property (p_seed_at_req) else $error("seed without request");
	property p_freeze; !ce |=> $stable(check_value) && $stable(rate) && $stable(cmd_busy); endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with ce low");
endmodule // bsc_boot_cmd_properties

// ---- tb/bsc_host_model.sv ----
`timescale 1ns/100ps
module bsc_host_model #(
	parameter int DIV0 = 32
) (
	input wire logic mclk,
	input wire logic txd,
	output logic     rxd
);
	// ****************************************************************
	// Serial host, 8N1, least significant bit first
	// ****************************************************************
	// The bench moves div only after an echo stop bit has ended or after a reset.
	int div = DIV0;

	initial rxd = 1'b1;

	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		@(posedge mclk);
		#1;
		for (int i = 0; i < 10; i++)
		begin
			rxd = f[i];
			repeat (div) @(posedge mclk);
			#1;
		end
	endtask

	task automatic recv(output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		d = 8'h00;
		// The line is read a step after each edge, once the device's new value has settled.
		while (txd === 1'b1 && n < 40 * div)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 40 * div)
			return;
		repeat (div / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (div) @(posedge mclk);
			#1;
			d[i] = txd;
		end
		repeat (div) @(posedge mclk);
		#1;
		ok = (txd === 1'b1);
	endtask
endmodule // bsc_host_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
	// ****************************************************************
	// Bench
	// ****************************************************************
	localparam int DV [4] = '{32, 24, 16, 8};
	logic               mclk = 1'b0;
	logic               sys_rst = 1'b1;
	logic               ce = 1'b1;
	wire                rxd;
	logic               txd;
	bsc_pkg::bsc_rate_t rate;
	logic [15:0]        check_value;
	logic               cmd_busy;
	int                 failures = 0;
	int                 n_checks = 0;
	logic [15:0]        crc;
	logic [15:0]        crc_prev;
	logic [15:0]        rx;
	logic [7:0]         b;
	logic [7:0]         codes [5] = '{8'hb1, 8'hb0, 8'hb3, 8'hb2, 8'hb3};

	always #2.5 mclk = ~mclk;

	bsc_boot_cmd #(.DIV_9600(DV[0]), .DIV_19200(DV[1]), .DIV_38400(DV[2]),
		.DIV_57600(DV[3])) dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .rxd(rxd),
		.txd(txd), .rate(rate), .check_value(check_value), .cmd_busy(cmd_busy));
	bsc_host_model #(.DIV0(DV[0])) host (.mclk(mclk), .txd(txd), .rxd(rxd));

	task wrap_up;
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			c = c[15] ? ((c << 1) ^ bsc_pkg::CRC_POLY) : (c << 1);
		return c;
	endfunction

	// Replies are gathered low byte first, so a one-byte echo lands in rx[15:8].
	task xfer(input logic [7:0] tx, input int nrx);
		logic [7:0] r;
		logic       ok;
		rx = 16'h0;
		fork
			host.send(tx);
			for (int i = 0; i < nrx; i++)
			begin
				host.recv(r, ok);
				check(ok, 1'b1);
				if (!ok)
					wrap_up();
				rx = {r, rx[15:8]};
			end
		join
	endtask

	initial
	begin
		void'($urandom(76));
		repeat (2) @(posedge mclk);
		#1 sys_rst = 1'b0;
		@(posedge mclk);
		#1;
		check(rate, bsc_pkg::RATE_RESET);
		check(check_value, bsc_pkg::CRC_SEED);
		xfer(bsc_pkg::CMD_CHECK, 2);
		check(rx, bsc_pkg::CRC_SEED);
		foreach (codes[i])
		begin
			xfer(codes[i], 1);
			check(rx[15:8], codes[i]);
			check(rate, codes[(i + 4) % 5][1:0] & {2{i != 0}});
			repeat (host.div / 2 + 3) @(posedge mclk);
			#1;
			check(rate, codes[i][1:0]);
			host.div = DV[codes[i][1:0]];
		end
		// An unknown first byte must be dropped without a reply.
		xfer(8'h50, 0);
		repeat (2) @(posedge mclk);
		#1;
		check(cmd_busy, 1'b0);
		crc = bsc_pkg::CRC_SEED;
		for (int pg = 0; pg < 2; pg++)
		begin
			xfer(bsc_pkg::CMD_PROG, 0);
			// The byte is taken a few cycles after its stop bit has been sent.
			repeat (2) @(posedge mclk);
			#1;
			check(cmd_busy, 1'b1);
			repeat (2) xfer(8'($urandom), 0);
			for (int i = 0; i < 256; i++)
			begin
				b = (pg == 0) ? 8'(i) : 8'($urandom);
				crc_prev = crc;
				crc = crc_upd(crc, b);
				xfer(b, 0);
			end
			// At the fastest rate the last byte is still waiting to be folded in here,
			// so a freeze now must hold it back until the enable returns.
			ce = 1'b0;
			repeat (4) @(posedge mclk);
			#1;
			check(check_value, crc_prev);
			check(cmd_busy, 1'b1);
			ce = 1'b1;
			repeat (2) @(posedge mclk);
			#1;
			check(check_value, crc);
			check(cmd_busy, 1'b0);
		end
		xfer(bsc_pkg::CMD_CHECK, 2);
		check(rx, crc);
		check(check_value, bsc_pkg::CRC_SEED);
		// Reset in the middle of a page; the link must then work again at the reset rate.
		xfer(bsc_pkg::CMD_PROG, 0);
		repeat (2) xfer(8'($urandom), 0);
		xfer(8'h5a, 0);
		repeat (2) @(posedge mclk);
		#1;
		check(check_value, crc_upd(bsc_pkg::CRC_SEED, 8'h5a));
		sys_rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1 sys_rst = 1'b0;
		@(posedge mclk);
		#1;
		check(rate, bsc_pkg::RATE_RESET);
		check(check_value, bsc_pkg::CRC_SEED);
		check(cmd_busy, 1'b0);
		host.div = DV[0];
		xfer(bsc_pkg::CMD_CHECK, 2);
		check(rx, bsc_pkg::CRC_SEED);
		wrap_up();
	end
endmodule // testbench

bind bsc_boot_cmd bsc_boot_cmd_properties #(.DIV_9600(DIV_9600), .DIV_19200(DIV_19200),
	.DIV_38400(DIV_38400), .DIV_57600(DIV_57600)) u_props (.mclk(mclk), .sys_rst(sys_rst),
	.ce(ce), .rxd(rxd), .txd(txd), .rate(rate), .check_value(check_value),
	.cmd_busy(cmd_busy));
